//--- rtl/cmam_map.vh
// constants and field layout for the cpu memory address map block
`ifndef CMAM_MAP_VH
`define CMAM_MAP_VH

`define CMAM_RESET_PC 16'h0000
`define CMAM_RESET_SP 8'h07
`define CMAM_VEC_BASE 16'h0003
`define CMAM_VEC_STEP_SHIFT 3
`define CMAM_PAGE_CTRL_RESET 8'h00
`define CMAM_PSEL_HI 7
`define CMAM_PSEL_LO 6
`define CMAM_PNUM_HI 5
`define CMAM_PNUM_LO 0
`define CMAM_PSW_BANK_HI 4
`define CMAM_PSW_BANK_LO 3
`define CMAM_AUX_PTR_SEL 0
`define CMAM_SFR_PAGE_CTRL 8'h80
`define CMAM_SFR_SP 8'h81
`define CMAM_SFR_DPL 8'h82
`define CMAM_SFR_DPH 8'h83
`define CMAM_SFR_IHIGH 8'hA0
`define CMAM_SFR_AUXILIARY_CONTROL_REG 8'hA2
`define CMAM_SFR_PSW 8'hD0
`define CMAM_LOWER_TOP 8'h7F
`define CMAM_BITRAM_BASE 8'h20
`define CMAM_SFR_WR_PULSE 1
// access kinds for internal data
`define CMAM_SPACE_LOWER 2'b00
`define CMAM_SPACE_UPPER 2'b01
`define CMAM_SPACE_SFR 2'b10

`endif

//--- rtl/cmam_top.v
// memory address map: program translation, internal data decode, sram strobes
`timescale 1ns/1ps
`include "cmam_map.vh"

module cmam_top (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // program fetch request
    input wire fetch_i,
    input wire [15:0] pc_i,
    input wire irq_take_i,
    input wire [4:0] irq_num_i,
    // external data access request
    input wire xrd_i,
    input wire xwr_i,
    input wire x_use_ri_i,
    input wire [7:0] ri_i,
    input wire [7:0] xwdata_i,
    // internal data access request
    input wire id_valid_i,
    input wire id_indirect_i,
    input wire id_write_i,
    input wire [7:0] id_addr_i,
    input wire [7:0] id_wdata_i,
    input wire [2:0] rn_i,
    input wire rn_valid_i,
    input wire [7:0] bit_addr_i,
    input wire bit_valid_i,
    // sram data input (pin side)
    input wire [7:0] mem_rdata_i,
    // fetch address outputs
    output reg [16:0] mem_addr_o,
    output reg prog_rd_o,
    output reg [15:0] pc_o,
    // sram data strobes
    output reg rd_n_o,
    output reg wr_n_o,
    output reg [7:0] mem_wdata_o,
    output reg mem_wdata_oe_o,
    output reg [7:0] mem_rdata_o,
    // internal data decode
    output reg [1:0] id_space_o,
    output reg [7:0] id_phys_o,
    output reg [7:0] id_rdata_o,
    output reg [7:0] rn_addr_o,
    output reg [6:0] bit_byte_o,
    output reg [2:0] bit_pos_o,
    output reg bit_ok_o,
    // state view
    output reg [7:0] sp_o,
    output reg [7:0] page_ctrl_o
);

    reg [7:0] page_ctrl_reg;
    reg [7:0] sp_reg;
    reg [7:0] ihigh_reg;
    reg [7:0] psw_reg;
    reg [7:0] auxiliary_control_reg_reg;
    reg [15:0] data_pointer_pair_reg [0:1];
    reg [15:0] pc_reg;
    reg [7:0] rdat_s1_reg;
    reg [7:0] rdat_s2_reg;
    reg [7:0] sfr_rd_next;
    reg [16:0] phys_next;
    reg [15:0] fetch_pc;
    reg [7:0] bit_byte_next;
    wire [1:0] bank;
    wire wr_sfr;
    wire ptr_sel;
    integer k;

    // extended page size in bytes from the select field
    function [16:0] cmam_page_size;
        input [1:0] sel;
        begin
            case (sel)
                2'b11: cmam_page_size = 17'h0_0000;
                2'b10: cmam_page_size = 17'h0_2000;
                2'b01: cmam_page_size = 17'h0_4000;
                default: cmam_page_size = 17'h0_8000;
            endcase
        end
    endfunction

    // common space size is 64K minus extended size
    function [16:0] cmam_common_size;
        input [1:0] sel;
        begin
            cmam_common_size = 17'h1_0000 - cmam_page_size(sel);
        end
    endfunction

    // space selection by address and mode
    function [1:0] cmam_space;
        input [7:0] addr;
        input indirect;
        begin
            // upper ram and special space share 80h-ffh; mode picks one
            if (addr <= `CMAM_LOWER_TOP) begin
                cmam_space = `CMAM_SPACE_LOWER;
            end else if (indirect) begin
                cmam_space = `CMAM_SPACE_UPPER;
            end else begin
                cmam_space = `CMAM_SPACE_SFR;
            end
        end
    endfunction

    assign bank = psw_reg[`CMAM_PSW_BANK_HI:`CMAM_PSW_BANK_LO];
    assign ptr_sel = auxiliary_control_reg_reg[`CMAM_AUX_PTR_SEL];
    assign wr_sfr = id_valid_i && id_write_i && !id_indirect_i &&
                    (id_addr_i > `CMAM_LOWER_TOP);

    // fetch address: vector or pc, then page translation
    always @* begin
        // vector request overrides the program counter
        if (irq_take_i) begin
            fetch_pc = `CMAM_VEC_BASE + {8'h00, irq_num_i, 3'b000};
        end else begin
            fetch_pc = pc_i;
        end
        // common space passes through; page number ignored there
        if ({1'b0, fetch_pc} < cmam_common_size(page_ctrl_reg[`CMAM_PSEL_HI:`CMAM_PSEL_LO])) begin
            phys_next = {1'b0, fetch_pc};
        end else begin
            // sum kept at 17 bits; wraps above the physical range
            phys_next = {1'b0, fetch_pc} + page_ctrl_reg[`CMAM_PNUM_HI:`CMAM_PNUM_LO] *
                cmam_page_size(page_ctrl_reg[`CMAM_PSEL_HI:`CMAM_PSEL_LO]);
        end
    end

    // special function read mux; unimplemented addresses return zero
    always @* begin
        case (id_addr_i)
            `CMAM_SFR_PAGE_CTRL: sfr_rd_next = page_ctrl_reg;
            `CMAM_SFR_SP: sfr_rd_next = sp_reg;
            `CMAM_SFR_DPL: sfr_rd_next = data_pointer_pair_reg[ptr_sel][7:0];
            `CMAM_SFR_DPH: sfr_rd_next = data_pointer_pair_reg[ptr_sel][15:8];
            `CMAM_SFR_IHIGH: sfr_rd_next = ihigh_reg;
            `CMAM_SFR_AUXILIARY_CONTROL_REG: sfr_rd_next = auxiliary_control_reg_reg;
            `CMAM_SFR_PSW: sfr_rd_next = psw_reg;
            default: sfr_rd_next = 8'h00;
        endcase
    end

    // bit address decode
    always @* begin
        // upper half: special registers ending in 0h or 8h
        if (bit_addr_i[7]) begin
            bit_byte_next = {bit_addr_i[7:3], 3'b000};
        end else begin
            // lower half: 16 bytes above the register banks
            bit_byte_next = `CMAM_BITRAM_BASE + {4'h0, bit_addr_i[6:3]};
        end
    end

    // register file for page control, stack and pointers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_ctrl_reg <= `CMAM_PAGE_CTRL_RESET;
            sp_reg <= `CMAM_RESET_SP;
            ihigh_reg <= 8'h00;
            psw_reg <= 8'h00;
            auxiliary_control_reg_reg <= 8'h00;
            for (k = 0; k < 2; k = k + 1) begin
                data_pointer_pair_reg[k] <= 16'h0000;
            end
        end else if (wr_sfr) begin
            // writes to unimplemented addresses are dropped
            case (id_addr_i)
                `CMAM_SFR_PAGE_CTRL: page_ctrl_reg <= id_wdata_i;
                `CMAM_SFR_SP: sp_reg <= id_wdata_i;
                `CMAM_SFR_DPL: data_pointer_pair_reg[ptr_sel][7:0] <= id_wdata_i;
                `CMAM_SFR_DPH: data_pointer_pair_reg[ptr_sel][15:8] <= id_wdata_i;
                `CMAM_SFR_IHIGH: ihigh_reg <= id_wdata_i;
                `CMAM_SFR_AUXILIARY_CONTROL_REG: auxiliary_control_reg_reg <= {id_wdata_i[7:3], 1'b0, id_wdata_i[1:0]};
                `CMAM_SFR_PSW: psw_reg <= id_wdata_i;
                default: sp_reg <= sp_reg;
            endcase
        end
    end

    // two-stage capture of sram read data from the pins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdat_s1_reg <= 8'h00;
            rdat_s2_reg <= 8'h00;
        end else begin
            rdat_s1_reg <= mem_rdata_i;
            rdat_s2_reg <= rdat_s1_reg;
        end
    end

    // shared sram bus: fetch and external data access
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_reg <= `CMAM_RESET_PC;
            mem_addr_o <= {1'b0, `CMAM_RESET_PC};
            prog_rd_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            mem_wdata_o <= 8'h00;
            mem_wdata_oe_o <= 1'b0;
        end else begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            prog_rd_o <= 1'b0;
            mem_wdata_oe_o <= 1'b0;
            if (xrd_i || xwr_i) begin
                // data space is its own 64K region of the shared sram
                if (x_use_ri_i) begin
                    mem_addr_o <= {1'b1, ihigh_reg, ri_i};
                end else begin
                    mem_addr_o <= {1'b1, data_pointer_pair_reg[ptr_sel]};
                end
                rd_n_o <= ~xrd_i;
                wr_n_o <= ~(xwr_i && !xrd_i);
                mem_wdata_o <= xwdata_i;
                mem_wdata_oe_o <= xwr_i && !xrd_i;
            end else if (fetch_i || irq_take_i) begin
                mem_addr_o <= phys_next;
                pc_reg <= fetch_pc;
                prog_rd_o <= 1'b1;
            end
        end
    end

    // internal data decode, read data and state view outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_space_o <= `CMAM_SPACE_LOWER;
            id_phys_o <= 8'h00;
            id_rdata_o <= 8'h00;
            rn_addr_o <= 8'h00;
            bit_byte_o <= 7'h00;
            bit_pos_o <= 3'b000;
            bit_ok_o <= 1'b0;
            mem_rdata_o <= 8'h00;
            pc_o <= `CMAM_RESET_PC;
            sp_o <= `CMAM_RESET_SP;
            page_ctrl_o <= `CMAM_PAGE_CTRL_RESET;
        end else begin
            id_space_o <= cmam_space(id_addr_i, id_indirect_i);
            id_phys_o <= id_addr_i;
            id_rdata_o <= sfr_rd_next;
            // bank bits sampled with the operand, not earlier
            if (rn_valid_i) begin
                rn_addr_o <= {3'b000, bank, rn_i};
            end
            if (bit_valid_i) begin
                bit_byte_o <= bit_byte_next[6:0];
                bit_pos_o <= bit_addr_i[2:0];
                bit_ok_o <= 1'b1;
            end
            mem_rdata_o <= rdat_s2_reg;
            pc_o <= pc_reg;
            sp_o <= sp_reg;
            page_ctrl_o <= page_ctrl_reg;
        end
    end

endmodule // cmam_top

//--- tb/cmam_sram_model.sv
// shared code and data sram behind the core's bus pins
`timescale 1ns/1ps
module cmam_sram_model (
    input wire clk_i,
    input wire [16:0] addr_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire [7:0] wdata_i,
    output wire [7:0] rdata_o
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00;
    // image already placed by the boot loader before the core runs
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    always @(posedge clk_i) begin
        if (!wr_n_i) mem[addr_i[7:0]] <= wdata_i;
        if (!rd_n_i) last <= mem[addr_i[7:0]];
    end
    // idle bus shows the inverse of the last byte
    assign rdata_o = !rd_n_i ? mem[addr_i[7:0]] : ~last;
endmodule // cmam_sram_model

//--- tb/cmam_top_asserts.sv
// concurrent checks on the memory map block's ports
`timescale 1ns/1ps
module cmam_top_asserts (
    input wire clk_i,
    input wire rst_n_i,
    input wire fetch_i,
    input wire [15:0] pc_i,
    input wire irq_take_i,
    input wire [4:0] irq_num_i,
    input wire xrd_i,
    input wire xwr_i,
    input wire id_valid_i,
    input wire id_indirect_i,
    input wire [7:0] id_addr_i,
    input wire [16:0] mem_addr_o,
    input wire prog_rd_o,
    input wire rd_n_o,
    input wire wr_n_o,
    input wire [1:0] id_space_o,
    input wire [7:0] sp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sp_reset_a: assert property ($rose(rst_n_i) |-> sp_o == 8'h07) else $error("sp");
    vec_addr_a: assert property (irq_take_i && !xrd_i && !xwr_i
        |=> mem_addr_o == {9'h000, $past(irq_num_i), 3'b011}) else $error("vector");
    fetch_low_a: assert property (fetch_i && !irq_take_i && !xrd_i && !xwr_i && !pc_i[15]
        |=> mem_addr_o == {1'b0, $past(pc_i)}) else $error("common fetch");
    fetch_take_a: assert property ((fetch_i || irq_take_i) && !xrd_i && !xwr_i
        |=> prog_rd_o) else $error("fetch pulse");
    data_space_a: assert property (xrd_i || xwr_i |=> !prog_rd_o && mem_addr_o[16])
        else $error("data space");
    rd_pulse_a: assert property (xrd_i ##1 !xrd_i |-> !rd_n_o ##1 rd_n_o)
        else $error("read strobe");
    wr_pulse_a: assert property (xwr_i && !xrd_i |=> !wr_n_o && rd_n_o)
        else $error("write strobe");
    upper_sel_a: assert property (id_valid_i && id_indirect_i && id_addr_i[7]
        |=> id_space_o == 2'b01) else $error("upper space");
    sfr_sel_a: assert property (id_valid_i && !id_indirect_i && id_addr_i[7]
        |=> id_space_o == 2'b10) else $error("sfr space");
    lower_sel_a: assert property (id_valid_i && !id_addr_i[7]
        |=> id_space_o == 2'b00) else $error("lower space");
endmodule // cmam_top_asserts
bind cmam_top cmam_top_asserts u_chk (.clk_i, .rst_n_i, .fetch_i, .pc_i, .irq_take_i,
    .irq_num_i, .xrd_i, .xwr_i, .id_valid_i, .id_indirect_i, .id_addr_i, .mem_addr_o,
    .prog_rd_o, .rd_n_o, .wr_n_o, .id_space_o, .sp_o);

//--- tb/cpu_memory_address_map_test.sv
// self-checking bench for the memory address map block
`timescale 1ns/1ps
module cpu_memory_address_map_test;
    logic clk_i = 0, rst_n_i = 0, fetch_i = 0, irq_take_i = 0, xrd_i = 0, xwr_i = 0;
    logic x_use_ri_i = 0, id_valid_i = 0, id_indirect_i = 0, id_write_i = 0;
    logic rn_valid_i = 0, bit_valid_i = 0;
    logic [15:0] pc_i = 0;
    logic [4:0] irq_num_i = 0;
    logic [2:0] rn_i = 0;
    logic [7:0] ri_i = 0, xwdata_i = 0, id_addr_i = 0, id_wdata_i = 0, bit_addr_i = 0;
    wire [7:0] mem_rdata_i, mem_wdata_o, mem_rdata_o, id_rdata_o, rn_addr_o, sp_o, page_ctrl_o;
    wire [7:0] id_phys_o;
    wire [16:0] mem_addr_o;
    wire [15:0] pc_o;
    wire [1:0] id_space_o;
    wire [6:0] bit_byte_o;
    wire [2:0] bit_pos_o;
    wire prog_rd_o, rd_n_o, wr_n_o, mem_wdata_oe_o, bit_ok_o;
    int failures = 0, num_checks = 0, cycles = 0;
    always #4 clk_i = ~clk_i;
    cmam_top dut (.clk_i, .rst_n_i, .fetch_i, .pc_i, .irq_take_i, .irq_num_i, .xrd_i, .xwr_i,
        .x_use_ri_i, .ri_i, .xwdata_i, .id_valid_i, .id_indirect_i, .id_write_i, .id_addr_i,
        .id_wdata_i, .rn_i, .rn_valid_i, .bit_addr_i, .bit_valid_i, .mem_rdata_i, .mem_addr_o,
        .prog_rd_o, .pc_o, .rd_n_o, .wr_n_o, .mem_wdata_o, .mem_wdata_oe_o, .mem_rdata_o,
        .id_space_o, .id_phys_o, .id_rdata_o, .rn_addr_o, .bit_byte_o, .bit_pos_o,
        .bit_ok_o, .sp_o, .page_ctrl_o);
    cmam_sram_model sram (.clk_i, .addr_i(mem_addr_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic id_op(logic wr, logic ind, logic [7:0] a, logic [7:0] d);
        id_valid_i = 1;
        id_write_i = wr;
        id_indirect_i = ind;
        id_addr_i = a;
        id_wdata_i = d;
        tick();
        id_valid_i = 0;
        id_write_i = 0;
    endtask
    task automatic xacc(logic rd, logic use_ri, logic [7:0] d);
        xrd_i = rd;
        xwr_i = !rd;
        x_use_ri_i = use_ri;
        xwdata_i = d;
        tick();
        xrd_i = 0;
        xwr_i = 0;
    endtask
    task automatic t_reset();
        tick(2);
        rst_n_i = 1;
        chk("reset", {8'h07, 8'h00, 1'b1}, {sp_o, page_ctrl_o, rd_n_o});
        chk("reset addr", 17'h00000, {pc_o, mem_addr_o[16]});
    endtask
    task automatic t_paging();
        logic [16:0] extended_page_size, common_space_size, pc;
        for (int s = 0; s < 4; s++) begin
            extended_page_size = (s == 3) ? 0 : 17'h08000 >> s;
            common_space_size = 17'h10000 - extended_page_size;
            id_op(1, 0, 8'h80, {s[1:0], 6'(s + 1)});
            for (int k = 0; k < 2; k++) begin
                pc = (s == 3) ? 17'h0FFFF : common_space_size - 1 + k;
                fetch_i = 1;
                pc_i = pc[15:0];
                tick();
                fetch_i = 0;
                chk("fetch", (pc < common_space_size) ? pc : pc + (s + 1) * extended_page_size, mem_addr_o);
                chk("fetch strobe", 1, prog_rd_o);
            end
            id_op(0, 0, 8'h80, 0);
            chk("page read", {s[1:0], 6'(s + 1)}, id_rdata_o);
        end
    endtask
    task automatic t_vector();
        id_op(1, 0, 8'h80, 8'h3F);
        for (int n = 0; n < 3; n++) begin
            irq_take_i = 1;
            fetch_i = 1;
            pc_i = 16'hC000;
            irq_num_i = (n == 2) ? 5'd31 : 5'(n);
            tick();
            irq_take_i = 0;
            fetch_i = 0;
            chk("vector", 17'h3 + 8 * irq_num_i, mem_addr_o);
        end
        tick();
        chk("vector pc", 17'h000FB, pc_o);
    endtask
    task automatic t_external_data_memory();
        id_op(1, 0, 8'h82, 8'h34);
        id_op(1, 0, 8'h83, 8'h12);
        xacc(0, 0, 8'h5A);
        chk("wr addr", 17'h11234, mem_addr_o);
        chk("wr pins", 11'h55A, {rd_n_o, wr_n_o, mem_wdata_oe_o, mem_wdata_o});
        fetch_i = 1;
        xacc(1, 0, 0);
        fetch_i = 0;
        chk("rd pins", 3'b010, {rd_n_o, wr_n_o, prog_rd_o});
        tick(3);
        chk("rd data", 8'h5A, mem_rdata_o);
        id_op(1, 0, 8'hA0, 8'h56);
        ri_i = 8'h78;
        xacc(1, 1, 0);
        chk("ri addr", 17'h15678, mem_addr_o);
        id_op(1, 0, 8'hA2, 8'h01);
        id_op(1, 0, 8'h82, 8'h77);
        xacc(1, 0, 0);
        chk("dptr1", 17'h10077, mem_addr_o);
        id_op(1, 0, 8'hA2, 8'h00);
        xacc(1, 0, 0);
        chk("dptr0", 17'h11234, mem_addr_o);
    endtask
    task automatic t_internal_data_memory();
        id_op(0, 1, 8'h90, 0);
        chk("upper", 2'b01, id_space_o);
        chk("phys", 8'h90, id_phys_o);
        id_op(0, 0, 8'h90, 0);
        chk("sfr", 2'b10, id_space_o);
        id_op(0, 1, 8'h10, 0);
        chk("lower", 2'b00, id_space_o);
        id_op(0, 0, 8'h84, 0);
        chk("unused sfr", 0, id_rdata_o);
        id_op(1, 0, 8'hD0, 8'h18);
        rn_valid_i = 1;
        rn_i = 3'd5;
        bit_valid_i = 1;
        bit_addr_i = 8'h2B;
        tick();
        rn_valid_i = 0;
        bit_valid_i = 0;
        chk("bank reg", 8'h1D, rn_addr_o);
        chk("bit", {7'h25, 3'd3, 1'b1}, {bit_byte_o, bit_pos_o, bit_ok_o});
        bit_valid_i = 1;
        bit_addr_i = 8'hD3;
        tick();
        bit_valid_i = 0;
        chk("sfr bit", {7'h50, 3'd3, 1'b1}, {bit_byte_o, bit_pos_o, bit_ok_o});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        t_reset();
        t_paging();
        t_vector();
        t_external_data_memory();
        t_internal_data_memory();
        tally_and_finish();
    end
endmodule // cpu_memory_address_map_test
